/* core/sssq_cfg.svh */
// constants of the start-up and protection sequencer
`ifndef SSSQ_CFG_SVH
`define SSSQ_CFG_SVH
// ----------------------------------------
// comparator input bit positions
// ----------------------------------------
`define SSSQ_NIN 15
`define SSSQ_I_TRIP 0
`define SSSQ_I_LOCKOUT 1
`define SSSQ_I_STARTUP 2
`define SSSQ_I_PROTIN 3
`define SSSQ_I_COMP 4
`define SSSQ_I_PFCSS 5
`define SSSQ_I_FBSS 6
`define SSSQ_I_FBTO 7
`define SSSQ_I_OVP 8
`define SSSQ_I_MSTOP 9
`define SSSQ_I_MSTART 10
`define SSSQ_I_MLOW 11
`define SSSQ_I_MHIGH 12
`define SSSQ_I_FLATCH 13
`define SSSQ_I_FSAFE 14
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define SSSQ_A_STATUS 12'h000
`define SSSQ_A_MASK 12'h004
`define SSSQ_A_STATE 12'h008
`define SSSQ_NEV 5
`define SSSQ_EV_LATCH 0
`define SSSQ_EV_SAFE 1
`define SSSQ_EV_OVP 2
`define SSSQ_EV_MSTOP 3
`define SSSQ_EV_CLEAR 4
`define SSSQ_MASK_RST 5'h00
`endif

/* core/sssq_pkg.sv */
// types of the start-up and protection sequencer
package sssq_pkg;
  typedef enum logic [2:0] {
    SSSQ_CHARGE,
    SSSQ_START,
    SSSQ_RUN,
    SSSQ_DROP,
    SSSQ_LATCHED
  } sssq_state_t;
endpackage : sssq_pkg

/* core/sssq_top.sv */
// start-up, lockout and protection sequencer with apb status
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "sssq_cfg.svh"
module sssq_top (
  input wire logic mclk,
  input wire logic rst,
  // comparator results, one bit per threshold
  input wire logic vcc_above_trip,
  input wire logic vcc_above_lockout,
  input wire logic vcc_above_startup,
  input wire logic prot_in_above_enable,
  input wire logic comp_at_enable_level,
  input wire logic pfc_ss_charged,
  input wire logic fb_ss_charged,
  input wire logic fb_at_timeout_level,
  input wire logic pfc_out_above_ovp,
  input wire logic mains_below_stop,
  input wire logic mains_above_start,
  input wire logic mains_below_reset_low,
  input wire logic mains_above_reset_high,
  input wire logic fault_latched,
  input wire logic fault_safe_restart,
  // actuator controls
  output logic hv_charge_en,
  output logic hv_charge_high,
  output logic core_en,
  output logic prot_src_en,
  output logic pfc_ss_src_en,
  output logic fb_ss_src_en,
  output logic comp_clamp_en,
  output logic pfc_gate_en,
  output logic flyback_gate_en,
  output logic [2:0] seq_state,
  output logic irq,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import sssq_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`SSSQ_NIN-1:0] raw_in;
  logic [`SSSQ_NIN-1:0] meta_ff;
  logic [`SSSQ_NIN-1:0] sync_ff;
  assign raw_in = {fault_safe_restart, fault_latched,
                   mains_above_reset_high, mains_below_reset_low,
                   mains_above_start, mains_below_stop,
                   pfc_out_above_ovp, fb_at_timeout_level,
                   fb_ss_charged, pfc_ss_charged,
                   comp_at_enable_level, prot_in_above_enable,
                   vcc_above_startup, vcc_above_lockout, vcc_above_trip};

  // analog edges are async to mclk, so meta_ff feeds sync_ff only
  genvar gi;
  generate
    for (gi = 0; gi < `SSSQ_NIN; gi = gi + 1) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= raw_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  logic s_trip, s_lock, s_start, s_prot, s_comp, s_pss, s_fss;
  logic s_fbto, s_ovp, s_mstop, s_mstart, s_mlow, s_mhigh;
  logic s_flatch, s_fsafe;
  // same bit order as raw_in and the input position constants
  assign {s_fsafe, s_flatch, s_mhigh, s_mlow, s_mstart, s_mstop, s_ovp,
          s_fbto, s_fss, s_pss, s_comp, s_prot, s_start, s_lock, s_trip} = sync_ff;

  // ----------------------------------------
  // sequencer state machine
  // ----------------------------------------
  sssq_state_t state_ff;
  sssq_state_t nxt_state;
  logic latch_pend_ff;
  logic prot_seen_ff;
  logic mains_ok_ff;
  logic mlow_seen_ff;
  logic latch_clear;
  logic trip_latched;
  logic trip_safe;
  // latched sources: feedback timeout and the latched fault input
  assign trip_latched = (state_ff == SSSQ_RUN) &&
                        ((flyback_gate_en && s_fbto) || s_flatch);
  assign trip_safe = (state_ff == SSSQ_RUN) && s_fsafe;
  assign latch_clear = (state_ff == SSSQ_LATCHED) && mlow_seen_ff && s_mhigh;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SSSQ_CHARGE: begin
        if (s_start) begin
          nxt_state = SSSQ_START;
        end
      end
      SSSQ_START, SSSQ_RUN: begin
        if (!s_lock) begin
          nxt_state = SSSQ_CHARGE;
        end else if (trip_latched || trip_safe) begin
          nxt_state = SSSQ_DROP;
        end else if (state_ff == SSSQ_START && prot_seen_ff) begin
          nxt_state = SSSQ_RUN;
        end
      end
      SSSQ_DROP: begin
        if (!s_lock) begin
          nxt_state = latch_pend_ff ? SSSQ_LATCHED : SSSQ_CHARGE;
        end
      end
      SSSQ_LATCHED: begin
        if (latch_clear) begin
          nxt_state = SSSQ_CHARGE;
        end
      end
      default: begin
        nxt_state = SSSQ_CHARGE;
      end
    endcase
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= SSSQ_CHARGE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // remembers which kind of protection is draining the supply
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch_pend_ff <= 1'b0;
    end else if (trip_latched) begin
      latch_pend_ff <= 1'b1;
    end else if (state_ff == SSSQ_CHARGE) begin
      latch_pend_ff <= 1'b0;
    end
  end
  // protection input must reach its level before leaving start-up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot_seen_ff <= 1'b0;
    end else if (state_ff == SSSQ_START && s_prot) begin
      prot_seen_ff <= 1'b1;
    end else if (state_ff != SSSQ_START && state_ff != SSSQ_RUN) begin
      prot_seen_ff <= 1'b0;
    end
  end
  // a drop of the protection input once running stops both, no latch
  logic prot_lost;
  assign prot_lost = (state_ff == SSSQ_RUN) && !s_prot;
  // mains hysteresis; starts blocked until the start level is seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mains_ok_ff <= 1'b0;
    end else if (s_mstop) begin
      mains_ok_ff <= 1'b0;
    end else if (s_mstart) begin
      mains_ok_ff <= 1'b1;
    end
  end
  // fast latch reset needs the low dip first, then the high level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mlow_seen_ff <= 1'b0;
    end else if (state_ff != SSSQ_LATCHED) begin
      mlow_seen_ff <= 1'b0;
    end else if (s_mlow) begin
      mlow_seen_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // actuator outputs, registered
  // ----------------------------------------
  logic active;
  logic recharge;
  logic nxt_pfc;
  logic nxt_fb;
  assign active = (state_ff == SSSQ_START) || (state_ff == SSSQ_RUN);
  assign recharge = (state_ff == SSSQ_CHARGE) || (state_ff == SSSQ_LATCHED);
  assign nxt_pfc = (state_ff == SSSQ_RUN) && s_prot && s_comp && s_pss &&
                   !s_ovp && mains_ok_ff && !trip_latched && !trip_safe &&
                   s_lock;
  assign nxt_fb = (state_ff == SSSQ_RUN) && s_fss && !trip_latched &&
                  !trip_safe && !prot_lost && s_lock;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hv_charge_en <= 1'b1;
      hv_charge_high <= 1'b0;
      core_en <= 1'b0;
      prot_src_en <= 1'b0;
      pfc_ss_src_en <= 1'b0;
      fb_ss_src_en <= 1'b0;
      comp_clamp_en <= 1'b0;
      pfc_gate_en <= 1'b0;
      flyback_gate_en <= 1'b0;
    end else begin
      // latched recharge stops at start-up level, without restarting
      hv_charge_en <= recharge && !(state_ff == SSSQ_LATCHED && s_start);
      hv_charge_high <= recharge && s_trip && !s_lock;
      core_en <= active || state_ff == SSSQ_DROP;
      prot_src_en <= active;
      pfc_ss_src_en <= active && !pfc_gate_en;
      fb_ss_src_en <= active;
      comp_clamp_en <= active;
      pfc_gate_en <= nxt_pfc;
      flyback_gate_en <= nxt_fb;
    end
  end
  assign seq_state = state_ff;

  // ----------------------------------------
  // event status, mask and interrupt
  // ----------------------------------------
  logic [`SSSQ_NEV-1:0] status_ff;
  logic [`SSSQ_NEV-1:0] mask_ff;
  logic [`SSSQ_NEV-1:0] events;
  logic ovp_d_ff;
  logic mstop_d_ff;
  logic wr_acc;
  logic [`SSSQ_NEV-1:0] w1c;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovp_d_ff <= 1'b0;
      mstop_d_ff <= 1'b0;
    end else begin
      ovp_d_ff <= s_ovp;
      mstop_d_ff <= s_mstop;
    end
  end

  assign events[`SSSQ_EV_LATCH] = trip_latched;
  assign events[`SSSQ_EV_SAFE] = trip_safe || (active && !s_lock);
  assign events[`SSSQ_EV_OVP] = s_ovp && !ovp_d_ff;
  assign events[`SSSQ_EV_MSTOP] = s_mstop && !mstop_d_ff;
  assign events[`SSSQ_EV_CLEAR] = latch_clear;
  assign wr_acc = psel && penable && pwrite;
  assign w1c = (wr_acc && paddr == `SSSQ_A_STATUS) ? pwdata[`SSSQ_NEV-1:0]
                                                     : '0;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~w1c) | events;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_ff <= `SSSQ_MASK_RST;
    end else if (wr_acc && paddr == `SSSQ_A_MASK) begin
      mask_ff <= pwdata[`SSSQ_NEV-1:0];
    end
  end
  assign irq = |(status_ff & mask_ff);

  // ----------------------------------------
  // apb read path
  // ----------------------------------------
  logic mapped;
  assign mapped = (paddr == `SSSQ_A_STATUS) || (paddr == `SSSQ_A_MASK) ||
                  (paddr == `SSSQ_A_STATE);
  assign pready = 1'b1; // never stalls: one access cycle
  assign pslverr = psel && penable && !mapped;

  // captured in setup so prdata comes from a flop in access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SSSQ_A_STATUS: prdata <= {27'h0000000, status_ff};
        `SSSQ_A_MASK: prdata <= {27'h0000000, mask_ff};
        `SSSQ_A_STATE: prdata <= {20'h00000, flyback_gate_en, pfc_gate_en,
                                  comp_clamp_en, prot_src_en, hv_charge_high,
                                  hv_charge_en, latch_pend_ff, mains_ok_ff,
                                  1'b0, seq_state};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  pfc_gate_cond_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(pfc_gate_en) |-> $past(s_prot) && $past(s_comp) && $past(s_pss))
    else $error("pfc enabled without all three conditions");
  fb_gate_cond_a: assert property (@(posedge mclk) disable iff (rst)
    flyback_gate_en |-> $past(s_fss))
    else $error("flyback enabled before soft-start charged");
  startup_entry_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_CHARGE && s_start |=> state_ff == SSSQ_START ##1 core_en && !hv_charge_en)
    else $error("start-up level did not start the sequence");
  drivers_off_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_CHARGE |=> !pfc_gate_en && !flyback_gate_en)
    else $error("driver on during safe restart");
  timeout_latch_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_RUN && flyback_gate_en && s_fbto && s_lock
      |=> state_ff == SSSQ_DROP && latch_pend_ff ##1 !flyback_gate_en)
    else $error("feedback timeout not latched");
  ovp_stop_a: assert property (@(posedge mclk) disable iff (rst)
    s_ovp |=> !pfc_gate_en)
    else $error("pfc switching during overvoltage");
  mains_hyst_a: assert property (@(posedge mclk) disable iff (rst)
    !mains_ok_ff && !s_mstart |=> !mains_ok_ff)
    else $error("mains restart below start level");
  latched_hold_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_LATCHED && !latch_clear |=> state_ff == SSSQ_LATCHED ##1 !pfc_gate_en)
    else $error("latched protection restarted");
  lockout_exit_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_RUN && !s_lock |=> state_ff == SSSQ_CHARGE ##1 !flyback_gate_en)
    else $error("lockout did not force safe restart");
  charge_level_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_CHARGE && s_lock |=> !hv_charge_high)
    else $error("high charge current above lockout");

  run_cov: cover property (@(posedge mclk) disable iff (rst)
    $rose(pfc_gate_en) ##[1:50] flyback_gate_en);
  latch_cov: cover property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_LATCHED ##[1:200] state_ff == SSSQ_CHARGE);
  safe_cov: cover property (@(posedge mclk) disable iff (rst)
    state_ff == SSSQ_DROP && !latch_pend_ff ##1 state_ff == SSSQ_CHARGE);
endmodule : sssq_top

/* verification/sssq_stage_model.sv */
// behavioural supply pin, soft-start pins and protect input around the sequencer
`timescale 1ns/100ps
module sssq_stage_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hv_charge_en,
  input wire logic hv_charge_high,
  input wire logic core_en,
  input wire logic prot_src_en,
  input wire logic pfc_ss_src_en,
  input wire logic fb_ss_src_en,
  input wire logic comp_clamp_en,
  input wire logic flyback_gate_en,
  input wire logic prot_block,
  input wire logic drain,
  output logic vcc_above_trip,
  output logic vcc_above_lockout,
  output logic vcc_above_startup,
  output logic prot_in_above_enable,
  output logic comp_at_enable_level,
  output logic pfc_ss_charged,
  output logic fb_ss_charged
);
  logic [6:0] vcc_ff;
  logic [1:0] div_ff;
  logic [3:0] prot_ff;
  logic [3:0] comp_ff;
  logic [3:0] pss_ff;
  logic [3:0] fss_ff;
  // supply: charged by hv, sags slowly unpowered, held by the aux winding
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vcc_ff <= 7'h00;
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (drain && vcc_ff != 7'h00) begin
        vcc_ff <= vcc_ff - 7'h01;
      end else if (hv_charge_en && vcc_ff < 7'h7C) begin
        vcc_ff <= vcc_ff + (hv_charge_high ? 7'h02 : 7'h01);
      end else if (!hv_charge_en && !flyback_gate_en && div_ff == 2'h0 && vcc_ff != 7'h00) begin
        vcc_ff <= vcc_ff - 7'h01;
      end
    end
  end
  // capacitor pins charge for eight cycles; protect input can be held down
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot_ff <= 4'h0;
      comp_ff <= 4'h0;
      pss_ff <= 4'h0;
      fss_ff <= 4'h0;
    end else begin
      prot_ff <= (!prot_src_en || prot_block) ? 4'h0 : prot_ff + {3'h0, prot_ff != 4'h8};
      comp_ff <= !core_en ? 4'h0 : comp_ff + {3'h0, comp_clamp_en && comp_ff != 4'h8};
      pss_ff <= !core_en ? 4'h0 : pss_ff + {3'h0, pfc_ss_src_en && pss_ff != 4'h8};
      fss_ff <= !core_en ? 4'h0 : fss_ff + {3'h0, fb_ss_src_en && fss_ff != 4'h8};
    end
  end
  // model thresholds: trip 16, lockout 40, start-up 64
  assign vcc_above_trip = vcc_ff > 7'h10;
  assign vcc_above_lockout = vcc_ff > 7'h28;
  assign vcc_above_startup = vcc_ff > 7'h40;
  assign prot_in_above_enable = prot_ff == 4'h8;
  assign comp_at_enable_level = comp_ff == 4'h8;
  assign pfc_ss_charged = pss_ff == 4'h8;
  assign fb_ss_charged = fss_ff == 4'h8;
endmodule : sssq_stage_model

/* verification/smps_startup_protection_sequencer_test.sv */
// self-checking bench for the start-up and protection sequencer
`timescale 1ns/100ps
`include "sssq_cfg.svh"
module smps_startup_protection_sequencer_test;
  import sssq_pkg::*;
  logic mclk = 0, rst = 1, prot_block = 1, drain = 0, psel = 0, penable = 0, pwrite = 0;
  logic fb_at_timeout_level = 0, pfc_out_above_ovp = 0, mains_below_stop = 0, mains_above_start = 0;
  logic mains_below_reset_low = 0, mains_above_reset_high = 0, fault_latched = 0, fault_safe_restart = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic vcc_above_trip, vcc_above_lockout, vcc_above_startup, prot_in_above_enable, comp_at_enable_level;
  logic pfc_ss_charged, fb_ss_charged, hv_charge_en, hv_charge_high, core_en, prot_src_en, pfc_ss_src_en;
  logic fb_ss_src_en, comp_clamp_en, pfc_gate_en, flyback_gate_en, irq, pready, pslverr, e;
  logic [2:0] seq_state;
  logic [5:0] outs;
  int mismatches = 0, checks_done = 0;
  assign outs = {hv_charge_en, core_en, prot_src_en, comp_clamp_en, pfc_gate_en, flyback_gate_en};
  always #20 mclk = ~mclk;
  sssq_top dut (.mclk, .rst, .vcc_above_trip, .vcc_above_lockout, .vcc_above_startup, .prot_in_above_enable,
    .comp_at_enable_level, .pfc_ss_charged, .fb_ss_charged, .fb_at_timeout_level, .pfc_out_above_ovp,
    .mains_below_stop, .mains_above_start, .mains_below_reset_low, .mains_above_reset_high, .fault_latched,
    .fault_safe_restart, .hv_charge_en, .hv_charge_high, .core_en, .prot_src_en, .pfc_ss_src_en, .fb_ss_src_en,
    .comp_clamp_en, .pfc_gate_en, .flyback_gate_en, .seq_state, .irq, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  sssq_stage_model u_model (.mclk, .rst, .hv_charge_en, .hv_charge_high, .core_en, .prot_src_en,
    .pfc_ss_src_en, .fb_ss_src_en, .comp_clamp_en, .flyback_gate_en, .prot_block, .drain, .vcc_above_trip,
    .vcc_above_lockout, .vcc_above_startup, .prot_in_above_enable, .comp_at_enable_level, .pfc_ss_charged,
    .fb_ss_charged);
  // --------------------------------
  // access and compare tasks
  // --------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  // output group under a mask of the bits that matter in that state
  task automatic chko(input logic [5:0] exp, input logic [5:0] msk);
    chk({26'h0, exp}, {26'h0, outs & msk});
  endtask : chko
  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) chk(32'h1, {31'h0, pready});
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chk(exp, d & msk);
  endtask : rd
  // bounded wait for a state, then two edges so the outputs follow
  task automatic wst(input logic [2:0] s);
    int n;
    n = 0;
    while (seq_state !== s && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 3000) chk({29'h0, s}, {29'h0, seq_state});
    repeat (2) @(posedge mclk);
  endtask : wst
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // --------------------------------
  // test sequence
  // --------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chko(6'h20, 6'h3F);
    rd(`SSSQ_A_STATUS, 32'h0, 32'hFFFFFFFF);
    rd(`SSSQ_A_MASK, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'h1, {31'h0, e});
    chk(32'h0, d);
    // charge level follows the supply bands
    while (u_model.vcc_ff < 7'h14) @(posedge mclk);
    repeat (6) @(posedge mclk);
    chk(32'h1, {31'h0, hv_charge_high});
    while (u_model.vcc_ff < 7'h2C) @(posedge mclk);
    repeat (6) @(posedge mclk);
    chk(32'h0, {31'h0, hv_charge_high});
    wst(SSSQ_START);
    chko(6'h1C, 6'h3C);
    chk(32'h3, {30'h0, pfc_ss_src_en, fb_ss_src_en});
    wst(SSSQ_CHARGE);
    chko(6'h20, 6'h33);
    prot_block <= 1'b0;
    wst(SSSQ_RUN);
    repeat (20) @(posedge mclk);
    chko(6'h01, 6'h03);
    mains_above_start <= 1'b1;
    repeat (10) @(posedge mclk);
    chko(6'h03, 6'h03);
    chk(32'h1, {30'h0, pfc_ss_src_en, fb_ss_src_en});
    rd(`SSSQ_A_STATE, 32'hF12, 32'hFFF);
    rd(`SSSQ_A_STATUS, 32'h2, 32'h1F);
    apb(1'b1, `SSSQ_A_STATUS, 32'h1F);
    apb(1'b1, `SSSQ_A_MASK, 32'h1B);
    pfc_out_above_ovp <= 1'b1;
    repeat (8) @(posedge mclk);
    chko(6'h01, 6'h03);
    rd(`SSSQ_A_STATUS, 32'h4, 32'h1F);
    chk(32'h0, {31'h0, irq});
    apb(1'b1, `SSSQ_A_MASK, 32'h1F);
    @(posedge mclk); // mask lands at the access edge, irq settles after it
    chk(32'h1, {31'h0, irq});
    apb(1'b1, `SSSQ_A_STATUS, 32'h4);
    rd(`SSSQ_A_STATUS, 32'h0, 32'h1F);
    chk(32'h0, {31'h0, irq});
    pfc_out_above_ovp <= 1'b0;
    repeat (8) @(posedge mclk);
    chko(6'h03, 6'h03);
    mains_above_start <= 1'b0;
    mains_below_stop <= 1'b1;
    repeat (8) @(posedge mclk);
    chko(6'h01, 6'h03);
    mains_below_stop <= 1'b0;
    repeat (8) @(posedge mclk);
    chko(6'h01, 6'h03);
    mains_above_start <= 1'b1;
    repeat (8) @(posedge mclk);
    chko(6'h03, 6'h03);
    rd(`SSSQ_A_STATUS, 32'h8, 32'h8);
    apb(1'b1, `SSSQ_A_STATUS, 32'h1F);
    fb_at_timeout_level <= 1'b1;
    wst(SSSQ_DROP);
    chko(6'h00, 6'h03);
    fb_at_timeout_level <= 1'b0;
    wst(SSSQ_LATCHED);
    repeat (200) @(posedge mclk);
    chk(32'h1, {31'h0, u_model.vcc_ff > 7'h28});
    chko(6'h00, 6'h03);
    rd(`SSSQ_A_STATUS, 32'h1, 32'h1);
    mains_above_reset_high <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({29'h0, SSSQ_LATCHED}, {29'h0, seq_state});
    mains_above_reset_high <= 1'b0;
    mains_below_reset_low <= 1'b1;
    repeat (8) @(posedge mclk);
    mains_below_reset_low <= 1'b0;
    mains_above_reset_high <= 1'b1;
    wst(SSSQ_CHARGE);
    mains_above_reset_high <= 1'b0;
    rd(`SSSQ_A_STATUS, 32'h10, 32'h10);
    wst(SSSQ_RUN);
    repeat (20) @(posedge mclk);
    fault_safe_restart <= 1'b1;
    wst(SSSQ_DROP);
    chko(6'h00, 6'h03);
    fault_safe_restart <= 1'b0;
    wst(SSSQ_CHARGE);
    wst(SSSQ_RUN);
    repeat (20) @(posedge mclk);
    drain <= 1'b1;
    wst(SSSQ_CHARGE);
    chko(6'h20, 6'h23);
    drain <= 1'b0;
    wst(SSSQ_START);
    end_of_test();
  end
  // watchdog well past the expected run length
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end
endmodule : smps_startup_protection_sequencer_test
